// file: hw/wotc_regs.sv
/*
 * wotc_regs: selective-wake oscillator trim, receiver select,
 * calibration readback and clock-recovery control registers.
 * Assumes the unlock field, restart request, calibration result and
 * falling-edge spacing measurement come from neighbouring logic.
 */
// Contract
// - trim code bits writable only while unlock field equals 11
// - trim bits 0..4 give a monotonic 32-step fine adjust; code feeds all eight fine trim bits 0..7 to the trim code
// - coarse trim bits 8..12 live in options bits 4:0
// - options bit 7 picks receiver, writable only when unlocked
// - reserved bits always read as zero
// - two read-only calibration bytes, cleared by power-on or soft reset
// - filter select 00/01/10 gives time constant 8/16/32
// - select 11 adapts constant to falling-edge spacing
// - control bit 0 enables recovery; reset value 0000 0100
// - restart clears recovery enable, keeps filter select
// - reset clears receiver select; restart keeps it
// - no reset forces a value onto the fine trim register
// - access is a 16-bit frame: address, mode bit, data
`timescale 1ns/100ps
`default_nettype none

module wotc_regs (
    // clock and resets
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_restart,
    // serial register port
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    output logic o_sdo,
    // neighbouring logic
    input wire logic [1:0] i_trim_unlock,
    input wire logic i_cal_valid,
    input wire logic [7:0] i_cal_high,
    input wire logic [7:0] i_cal_low,
    input wire logic [3:0] i_edge_spacing,
    // block outputs
    output logic [12:0] o_oscillator_trim_code,
    output logic o_wake_receiver_select,
    output logic o_recovery_enable,
    output logic [5:0] o_filter_time_constant
);
    wotc_frame_if frm ();

    wotc_frame_rx u_frame (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_sclk(i_sclk),
        .i_sdi(i_sdi),
        .frm(frm)
    );

    logic [7:0] fine_trim;
    logic [4:0] coarse_trim;
    logic rx_select;
    logic [7:0] cal_high;
    logic [7:0] cal_low;
    logic [1:0] filt_sel;
    logic recovery_enable;
    logic unlocked;
    logic wr;
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic [15:0] out_shift;
    logic sclk_q;
    logic cs_n_q;
    logic [5:0] next_tc;

    assign unlocked = (i_trim_unlock == wotc_pkg::TRIM_UNLOCK_CODE);
    assign wr = frm.strobe && frm.write;

    // ------------------------------------------------------------------
    // fine trim
    // ------------------------------------------------------------------
    // no reset term: keeps trimmed contents over every reset
    // all eight bits feed the oscillator unchanged
    always_ff @(posedge i_clk) begin
        if (wr && unlocked && frm.addr == wotc_pkg::ADDR_OSC_FINE_TRIM)
            fine_trim <= frm.wdata;
    end

    // ------------------------------------------------------------------
    // options and coarse trim
    // ------------------------------------------------------------------
    // coarse trim, not forced by any reset
    always_ff @(posedge i_clk) begin
        if (wr && unlocked &&
                frm.addr == wotc_pkg::ADDR_WAKE_OPTIONS_COARSE_TRIM)
            coarse_trim <= frm.wdata[wotc_pkg::OPT_COARSE_MSB:0];
    end

    // cleared by reset, held across restart
    always_ff @(posedge i_clk) begin
        if (i_rst)
            rx_select <= 1'b0;
        else if (wr && unlocked &&
                frm.addr == wotc_pkg::ADDR_WAKE_OPTIONS_COARSE_TRIM)
            rx_select <= frm.wdata[wotc_pkg::OPT_RX_SEL_BIT];
    end

    // ------------------------------------------------------------------
    // calibration readback
    // ------------------------------------------------------------------
    // captured from the calibration engine only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cal_high <= wotc_pkg::CAL_RESET;
            cal_low <= wotc_pkg::CAL_RESET;
        end else if (i_cal_valid) begin
            cal_high <= i_cal_high;
            cal_low <= i_cal_low;
        end
    end

    // ------------------------------------------------------------------
    // clock recovery control
    // ------------------------------------------------------------------
    // reset gives disabled, constant 16
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            filt_sel <= wotc_pkg::FILT_RESET;
        end else if (wr &&
                frm.addr == wotc_pkg::ADDR_CLOCK_RECOVERY_CONTROL_ONE) begin
            filt_sel <= frm.wdata[wotc_pkg::CDR_FILT_MSB:
                                  wotc_pkg::CDR_FILT_LSB];
        end
    end

    // restart drops enable but leaves filter select
    always_ff @(posedge i_clk) begin
        if (i_rst || i_restart)
            recovery_enable <= 1'b0;
        else if (wr &&
                frm.addr == wotc_pkg::ADDR_CLOCK_RECOVERY_CONTROL_ONE)
            recovery_enable <= frm.wdata[wotc_pkg::RECOVERY_ENABLE_BIT];
    end

    // fixed constants, adaptive by edge spacing
    always_comb begin
        next_tc = wotc_pkg::TC_16;
        case (wotc_pkg::wotc_filt_t'(filt_sel))
            wotc_pkg::WOTC_FILT_8: next_tc = wotc_pkg::TC_8;
            wotc_pkg::WOTC_FILT_16: next_tc = wotc_pkg::TC_16;
            wotc_pkg::WOTC_FILT_32: next_tc = wotc_pkg::TC_32;
            default: begin
                if (i_edge_spacing <= wotc_pkg::EDGE_FAST_MAX)
                    next_tc = wotc_pkg::TC_32;
                else if (i_edge_spacing <= wotc_pkg::EDGE_MID_MAX)
                    next_tc = wotc_pkg::TC_16;
                else
                    next_tc = wotc_pkg::TC_8;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_oscillator_trim_code <= 13'h0000;
            o_wake_receiver_select <= 1'b0;
            o_recovery_enable <= 1'b0;
            o_filter_time_constant <= wotc_pkg::TC_16;
        end else begin
            o_oscillator_trim_code <= {coarse_trim, fine_trim};
            o_wake_receiver_select <= rx_select;
            o_recovery_enable <= recovery_enable;
            o_filter_time_constant <= next_tc;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // reserved bits return zero
    always_comb begin
        if (frm.addr == wotc_pkg::ADDR_OSC_FINE_TRIM)
            next_rdata = fine_trim;
        else if (frm.addr == wotc_pkg::ADDR_WAKE_OPTIONS_COARSE_TRIM)
            next_rdata = {rx_select, 2'b00, coarse_trim};
        else if (frm.addr == wotc_pkg::ADDR_OSC_CALIBRATION_HIGH)
            next_rdata = cal_high;
        else if (frm.addr == wotc_pkg::ADDR_OSC_CALIBRATION_LOW)
            next_rdata = cal_low;
        else if (frm.addr == wotc_pkg::ADDR_CLOCK_RECOVERY_CONTROL_ONE)
            next_rdata = {4'h0, filt_sel, 1'b0, recovery_enable};
        else
            next_rdata = 8'h00;
    end

    // read data of a frame comes back in the next frame's data byte
    always_ff @(posedge i_clk) begin
        if (i_rst)
            rdata <= 8'h00;
        else if (frm.strobe)
            rdata <= next_rdata;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= i_sclk;
            cs_n_q <= i_cs_n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            out_shift <= 16'h0000;
        else if (!i_cs_n && cs_n_q)
            out_shift <= {8'h00, rdata};
        else if (!i_cs_n && !i_sclk && sclk_q)
            out_shift <= {out_shift[14:0], 1'b0};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst)
            o_sdo <= 1'b0;
        else
            o_sdo <= out_shift[15];
    end
endmodule : wotc_regs

`default_nettype wire

// file: include/wotc_pkg.sv
/*
 * wotc_pkg: register offsets, field positions, reset values and filter
 * constants of the selective-wake trim and recovery register bank.
 * Assumes a 7-bit register address space reached by 16-bit serial frames.
 */
`default_nettype none

package wotc_pkg;
    // ------------------------------------------------------------------
    // register addresses (7-bit)
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_OSC_FINE_TRIM = 7'h38;
    localparam logic [6:0] ADDR_WAKE_OPTIONS_COARSE_TRIM = 7'h39;
    localparam logic [6:0] ADDR_OSC_CALIBRATION_HIGH = 7'h3a;
    localparam logic [6:0] ADDR_OSC_CALIBRATION_LOW = 7'h3b;
    localparam logic [6:0] ADDR_CLOCK_RECOVERY_CONTROL_ONE = 7'h3c;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int OPT_RX_SEL_BIT = 7;
    localparam int OPT_COARSE_MSB = 4;
    localparam int CDR_FILT_MSB = 3;
    localparam int CDR_FILT_LSB = 2;
    localparam int RECOVERY_ENABLE_BIT = 0;
    localparam logic [1:0] TRIM_UNLOCK_CODE = 2'h3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CAL_RESET = 8'h00;
    localparam logic [1:0] FILT_RESET = 2'h1;

    // ------------------------------------------------------------------
    // frame layout and filter constants
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int FRAME_CNT_W = 4;
    localparam int FRAME_WRITE_BIT = 7;

    typedef enum logic [1:0] {
        WOTC_FILT_8 = 2'b00,
        WOTC_FILT_16 = 2'b01,
        WOTC_FILT_32 = 2'b10,
        WOTC_FILT_ADAPT = 2'b11
    } wotc_filt_t;

    localparam logic [5:0] TC_8 = 6'h08;
    localparam logic [5:0] TC_16 = 6'h10;
    localparam logic [5:0] TC_32 = 6'h20;
    localparam logic [3:0] EDGE_FAST_MAX = 4'h3;
    localparam logic [3:0] EDGE_MID_MAX = 4'h8;
endpackage : wotc_pkg

`default_nettype wire

// file: include/wotc_frame_if.sv
/*
 * wotc_frame_if: one decoded serial register access, passed from the
 * frame shifter to the register bank.
 * Assumes one clock domain; strobe is one cycle wide.
 */
`timescale 1ns/100ps
`default_nettype none

interface wotc_frame_if;
    logic strobe;
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;

    modport src (output strobe, output write, output addr, output wdata);
    modport dst (input strobe, input write, input addr, input wdata);
endinterface : wotc_frame_if

`default_nettype wire

// file: hw/wotc_frame_rx.sv
/*
 * wotc_frame_rx: shifts 16 serial bits (address byte first, msb first)
 * and emits one decoded access when the frame closes.
 * Assumes chip select and serial clock sampled synchronously to i_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module wotc_frame_rx (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial pins (synchronous samples)
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    // decoded access
    wotc_frame_if.src frm
);
    logic [15:0] shift;
    logic [wotc_pkg::FRAME_CNT_W:0] count;
    logic sclk_q;
    logic cs_n_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= i_sclk;
            cs_n_q <= i_cs_n;
        end
    end

    // ------------------------------------------------------------------
    // shift on rising serial clock inside the frame
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst || i_cs_n) begin
            count <= '0;
            shift <= 16'h0000;
        end else if (i_sclk && !sclk_q) begin
            shift <= {shift[14:0], i_sdi};
            if (count != 5'(wotc_pkg::FRAME_BITS))
                count <= count + 5'h01;
        end
    end

    // 16-bit frame decode
    // short frames are dropped: no partial register update; long frames decode their last 16 bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            frm.strobe <= 1'b0;
            frm.write <= 1'b0;
            frm.addr <= 7'h00;
            frm.wdata <= 8'h00;
        end else begin
            frm.strobe <= i_cs_n && !cs_n_q &&
                (count == 5'(wotc_pkg::FRAME_BITS));
            frm.addr <= shift[15:9];
            frm.write <= shift[8];
            frm.wdata <= shift[7:0];
        end
    end
endmodule : wotc_frame_rx

`default_nettype wire

// file: dv/wotc_regs_sva.sv
/* wotc_regs_sva: port-level checks of the trim and recovery register bank.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module wotc_regs_sva (
    // clock and resets
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_restart,
    // serial port
    input wire logic i_cs_n,
    input wire logic o_sdo,
    // block outputs
    input wire logic [12:0] o_oscillator_trim_code,
    input wire logic o_wake_receiver_select,
    input wire logic o_recovery_enable,
    input wire logic [5:0] o_filter_time_constant
);
    // ----------------------------------------------------------------
    // quiet time since last frame
    // ----------------------------------------------------------------
    // commits land within three edges; frame gaps last six cycles, so
    // the hold checks only look at idle spans, after the trim is written
    logic [3:0] quiet;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_cs_n) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    AST_EN_RST:
        assert property (@(posedge i_clk) i_rst [*3] |-> !o_recovery_enable)
        else $error("recovery enable set in reset");
    AST_TC_RST:
        assert property (@(posedge i_clk)
            i_rst [*3] |-> o_filter_time_constant == 6'h10)
        else $error("time constant not 16 in reset");
    AST_RX_RST:
        assert property (@(posedge i_clk)
            i_rst [*3] |-> !o_wake_receiver_select)
        else $error("receiver select set in reset");
    AST_SDO_RST:
        assert property (@(posedge i_clk) i_rst [*3] |-> !o_sdo)
        else $error("serial out high in reset");
    AST_EN_RESTART:
        assert property (@(posedge i_clk) disable iff (i_rst)
            i_restart [*3] |-> !o_recovery_enable)
        else $error("recovery enable kept over restart");
    AST_TC_LEGAL:
        assert property (@(posedge i_clk) disable iff (i_rst)
            o_filter_time_constant inside {6'h08, 6'h10, 6'h20})
        else $error("time constant out of set");
    AST_TRIM_HOLD:
        assert property (@(posedge i_clk) disable iff (i_rst)
            quiet > 4'h6 |=> $stable(o_oscillator_trim_code))
        else $error("trim code moved without a frame");
    AST_RX_HOLD:
        assert property (@(posedge i_clk) disable iff (i_rst)
            quiet > 4'h6 |=> $stable(o_wake_receiver_select))
        else $error("receiver select moved without a frame");
    AST_EN_HOLD:
        assert property (@(posedge i_clk) disable iff (i_rst)
            quiet > 4'h6 && !i_restart && !$past(i_restart)
            && !$past(i_restart, 2) |=> $stable(o_recovery_enable))
        else $error("recovery enable moved without a frame");
endmodule : wotc_regs_sva
bind wotc_regs wotc_regs_sva u_sva (.i_clk, .i_rst, .i_restart, .i_cs_n,
    .o_sdo, .o_oscillator_trim_code, .o_wake_receiver_select,
    .o_recovery_enable, .o_filter_time_constant);
`default_nettype wire

// file: dv/testbench.sv
/* testbench: drives serial frames into the register bank and checks
   read answers and outputs. Assumes the bound checker alongside. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_restart = 1'b0;
    logic i_cs_n = 1'b1;
    logic i_sclk = 1'b0;
    logic i_sdi = 1'b0;
    logic [1:0] i_trim_unlock = 2'h0;
    logic i_cal_valid = 1'b0;
    logic [7:0] i_cal_high = 8'h00;
    logic [7:0] i_cal_low = 8'h00;
    logic [3:0] i_edge_spacing = 4'h0;
    logic o_sdo, o_wake_receiver_select, o_recovery_enable;
    logic [12:0] o_oscillator_trim_code;
    logic [5:0] o_filter_time_constant;
    logic [7:0] exp_q[$];
    logic [15:0] rx;
    logic [31:0] seed = 32'h4c;
    logic [31:0] r;
    logic [7:0] v;
    logic prev_rd = 1'b0;
    int bad_count = 0;
    int samples_checked = 0;
    event got;
    logic [3:0] sp[4] = '{4'h3, 4'h4, 4'h8, 4'h9};
    logic [5:0] tc[4] = '{6'h20, 6'h10, 6'h10, 6'h08};
    always #12.5 i_clk = ~i_clk;
    wotc_regs DUT (.i_clk, .i_rst, .i_restart, .i_cs_n, .i_sclk, .i_sdi,
        .o_sdo, .i_trim_unlock, .i_cal_valid, .i_cal_high, .i_cal_low,
        .i_edge_spacing, .o_oscillator_trim_code, .o_wake_receiver_select,
        .o_recovery_enable, .o_filter_time_constant);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic nclk(input int n);
        repeat (n) @(negedge i_clk);
    endtask : nclk
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic outs(input logic x, input logic e, input logic [5:0] t);
        chk({7'h0, o_wake_receiver_select, o_recovery_enable, 1'b0,
            o_filter_time_constant}, {7'h0, x, e, 1'b0, t});
    endtask : outs
    // answer of a read shows in the next frame, so sample sdo each bit
    task automatic frame(input logic [6:0] a, input logic w,
                         input logic [7:0] d);
        logic [15:0] f;
        f = {a, w, d};
        i_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            i_sdi = f[i];
            nclk(4);
            rx = {rx[14:0], o_sdo};
            i_sclk = 1'b1;
            nclk(2);
            i_sclk = 1'b0;
        end
        nclk(2);
        i_cs_n = 1'b1;
        nclk(6);
        if (prev_rd) ->got;
        prev_rd = !w;
    endtask : frame
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        frame(a, 1'b0, 8'h00);
    endtask : rd
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    initial forever begin
        @got;
        chk(rx, {8'h00, exp_q.pop_front()});
    end
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        nclk(16);
        i_rst = 1'b0;
        nclk(2);
        outs(1'b0, 1'b0, 6'h10);
        rd(7'h3c, 8'h04);
        rd(7'h3a, 8'h00);
        rd(7'h3b, 8'h00);
        rd(7'h7f, 8'h00);
        $display("reset test done");
        r = rnd();
        v = r[7:0];
        i_trim_unlock = 2'h3;
        // trim written while unlocked; later writes while locked leave it unchanged
        frame(7'h38, 1'b1, v);
        frame(7'h39, 1'b1, 8'hff);
        rd(7'h38, v);
        rd(7'h39, 8'h9f);
        chk({3'h0, o_oscillator_trim_code}, {3'h0, 5'h1f, v});
        i_trim_unlock = (r[9:8] == 2'h3) ? 2'h0 : r[9:8];
        frame(7'h38, 1'b1, {v[7:5], ~v[4:0]});
        frame(7'h39, 1'b1, 8'h00);
        rd(7'h38, v);
        rd(7'h39, 8'h9f);
        chk({3'h0, o_oscillator_trim_code}, {3'h0, 5'h1f, v});
        $display("lock test done");
        i_cal_high = r[23:16];
        i_cal_low = r[31:24];
        i_cal_valid = 1'b1;
        nclk(1);
        i_cal_valid = 1'b0;
        frame(7'h3a, 1'b1, ~r[23:16]);
        frame(7'h3b, 1'b1, ~r[31:24]);
        rd(7'h3a, r[23:16]);
        rd(7'h3b, r[31:24]);
        $display("calibration test done");
        frame(7'h3c, 1'b1, 8'hff);
        rd(7'h3c, 8'h0d);
        for (int s = 0; s < 3; s++) begin
            frame(7'h3c, 1'b1, {4'h0, s[1:0], 2'h1});
            outs(1'b1, 1'b1, 6'h08 << s);
        end
        frame(7'h3c, 1'b1, 8'h0d);
        for (int k = 0; k < 4; k++) begin
            i_edge_spacing = sp[k];
            nclk(4);
            outs(1'b1, 1'b1, tc[k]);
        end
        $display("filter test done");
        frame(7'h3c, 1'b1, 8'h09);
        i_restart = 1'b1;
        nclk(3);
        i_restart = 1'b0;
        nclk(3);
        outs(1'b1, 1'b0, 6'h20);
        rd(7'h3c, 8'h08);
        rd(7'h38, v);
        // reset drops a pending answer, so collect it first
        frame(7'h7f, 1'b1, 8'h00);
        i_rst = 1'b1;
        nclk(4);
        i_rst = 1'b0;
        nclk(2);
        outs(1'b0, 1'b0, 6'h10);
        rd(7'h39, 8'h1f);
        rd(7'h38, v);
        rd(7'h3c, 8'h04);
        frame(7'h7f, 1'b0, 8'h00);
        $display("restart test done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
